// ==== rtl/system_power_mode_control.sv ====
// system and power mode control register bank with its mode and report timing
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.svh"
module system_power_mode_control #(
  parameter int MS_CYCLES = `SPM_REPORT_UNIT_NS / `SPM_CORE_CLK_PERIOD_NS
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_wdata,
  output var  logic [7:0]              reg_rdata,
  input  wire logic                    tuning_busy,
  input  wire logic                    tuning_done,
  input  wire logic                    reseed_done,
  input  wire spm_pkg::power_mode_type auto_request,
  input  wire logic                    pwm_signal,
  input  wire logic                    inductive_tx_signal,
  output var  logic                    device_reset,
  output var  logic                    reset_event,
  output wire logic                    event_mode,
  output wire logic                    slow_oscillator_select,
  output wire logic                    comms_allowed,
  output wire logic                    retune_band_select,
  output var  logic                    tuning_start,
  output var  logic                    reseed_all,
  output wire logic [5:0]              channel_enable,
  output wire logic                    hall_ui_ready,
  output wire logic                    temperature_ui_ready,
  output wire logic                    sar_ui_ready,
  output wire logic                    hysteresis_ui_ready,
  output wire logic                    general_pin_three_out,
  output wire logic                    inductive_transmit_enable,
  output var  spm_pkg::power_mode_type active_mode,
  output wire logic                    conversions_enable,
  output wire logic                    wake_channel_only,
  output wire logic                    report_tick,
  output var  logic                    segment_tick
);
  import spm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [3:0] sys_cfg_q;      // event, slow osc, comms, band (bits 5..2)
  logic       soft_pend_q;    // soft reset in progress
  logic       rerun_pend_q;   // tuning rerun in progress
  logic       rerun_issued_q; // start pulse already sent for this rerun
  logic       reseed_pend_q;  // reseed in progress
  logic       reseed_issued_q;
  logic [5:0] chan_en_q;      // channel enables
  logic [7:0] pmode_q;        // power mode control
  logic [7:0] np_int_q;       // normal interval, ms
  logic [7:0] lp_int_q;       // low interval, ms
  logic [7:0] ulp_int_q;      // deep interval, 16 ms units

  //////////////////////////////////////////////////////////////////////////////
  // write decode
  wire wr_sys  = reg_wr && (reg_addr == `SPM_SYSTEM_CONTROL_OFS);
  wire wr_chan = reg_wr && (reg_addr == `SPM_CHANNEL_ENABLES_OFS);
  wire wr_pm   = reg_wr && (reg_addr == `SPM_POWER_MODE_CONTROL_OFS);
  wire wr_np   = reg_wr && (reg_addr == `SPM_NORMAL_INTERVAL_OFS);
  wire wr_lp   = reg_wr && (reg_addr == `SPM_LOW_INTERVAL_OFS);
  wire wr_ulp  = reg_wr && (reg_addr == `SPM_ULTRALOW_INTERVAL_OFS);
  // action requests, a written zero does nothing
  wire soft_req   = wr_sys && reg_wdata[`SPM_SOFT_RESET_BIT];
  wire ack_req    = wr_sys && reg_wdata[`SPM_ACK_RESET_BIT];
  wire rerun_req  = wr_sys && reg_wdata[`SPM_RERUN_TUNING_BIT];
  wire reseed_req = wr_sys && reg_wdata[`SPM_RESEED_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // soft reset: one cycle pending, then every register takes its default
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_pend_q <= 1'b0;
    end else begin
      soft_pend_q <= soft_req && !soft_pend_q;
    end
  end
  assign device_reset = soft_pend_q;

  // reset event: set by any reset, set wins over acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_event <= 1'b1;
    end else if (soft_pend_q) begin
      reset_event <= 1'b1;
    end else if (ack_req) begin
      reset_event <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_cfg_q <= 4'(`SPM_SYSTEM_CONTROL_RST >> 2);
      chan_en_q <= `SPM_CHANNEL_ENABLES_RST;
      pmode_q   <= `SPM_POWER_MODE_CONTROL_RST;
      np_int_q  <= `SPM_NORMAL_INTERVAL_RST;
      lp_int_q  <= `SPM_LOW_INTERVAL_RST;
      ulp_int_q <= `SPM_ULTRALOW_INTERVAL_RST;
    end else if (soft_pend_q) begin
      // watchdog style reload
      sys_cfg_q <= 4'(`SPM_SYSTEM_CONTROL_RST >> 2);
      chan_en_q <= `SPM_CHANNEL_ENABLES_RST;
      pmode_q   <= `SPM_POWER_MODE_CONTROL_RST;
      np_int_q  <= `SPM_NORMAL_INTERVAL_RST;
      lp_int_q  <= `SPM_LOW_INTERVAL_RST;
      ulp_int_q <= `SPM_ULTRALOW_INTERVAL_RST;
    end else begin
      if (wr_sys)  sys_cfg_q <= reg_wdata[5:2];
      if (wr_chan) chan_en_q <= reg_wdata[5:0];
      if (wr_pm)   pmode_q   <= reg_wdata;
      if (wr_np)   np_int_q  <= reg_wdata;
      if (wr_lp)   lp_int_q  <= reg_wdata;
      if (wr_ulp)  ulp_int_q <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tuning rerun and reseed: pending until the engine reports done
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rerun_pend_q    <= 1'b0;
      rerun_issued_q  <= 1'b0;
      reseed_pend_q   <= 1'b0;
      reseed_issued_q <= 1'b0;
      tuning_start    <= 1'b0;
      reseed_all      <= 1'b0;
    end else if (soft_pend_q) begin
      rerun_pend_q    <= 1'b0;
      rerun_issued_q  <= 1'b0;
      reseed_pend_q   <= 1'b0;
      reseed_issued_q <= 1'b0;
      tuning_start    <= 1'b0;
      reseed_all      <= 1'b0;
    end else begin
      // one start pulse per request, bit clears on completion
      tuning_start   <= rerun_req && !rerun_pend_q;
      rerun_issued_q <= (rerun_issued_q || tuning_start) && !tuning_done;
      if (rerun_req && !rerun_pend_q) begin
        rerun_pend_q <= 1'b1;
      end else if (tuning_done && (rerun_issued_q || tuning_start)) begin
        rerun_pend_q <= 1'b0;
      end
      // reseed ignores per channel reseed enables
      reseed_all      <= reseed_req && !reseed_pend_q;
      reseed_issued_q <= (reseed_issued_q || reseed_all) && !reseed_done;
      if (reseed_req && !reseed_pend_q) begin
        reseed_pend_q <= 1'b1;
      end else if (reseed_done && (reseed_issued_q || reseed_all)) begin
        reseed_pend_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration outputs
  assign event_mode             = sys_cfg_q[`SPM_EVENT_MODE_BIT - 2];
  assign slow_oscillator_select = sys_cfg_q[`SPM_SLOW_OSC_BIT - 2];
  assign retune_band_select     = sys_cfg_q[`SPM_RETUNE_BAND_BIT - 2];
  // tuning in progress silences comms unless allowed
  assign comms_allowed = sys_cfg_q[`SPM_COMMS_TUNING_BIT - 2] || !(tuning_busy || rerun_pend_q);
  assign channel_enable       = chan_en_q;
  assign hall_ui_ready        = chan_en_q[4] && chan_en_q[5];
  assign temperature_ui_ready = chan_en_q[3];
  assign sar_ui_ready         = chan_en_q[0] && chan_en_q[1];
  assign hysteresis_ui_ready  = chan_en_q[2];
  // pin three carries pwm or inductive transmit
  wire pwm_active = pmode_q[`SPM_PWM_OUT_BIT];
  assign general_pin_three_out     = pwm_active ? pwm_signal : inductive_tx_signal;
  assign inductive_transmit_enable = !pwm_active;

  //////////////////////////////////////////////////////////////////////////////
  // mode choice
  power_mode_type manual_mode; // manual field as a mode
  assign manual_mode = power_mode_type'(pmode_q[`SPM_MANUAL_MODE_HI:`SPM_MANUAL_MODE_LO]);
  power_mode_select u_mode_select (
    .auto_switch_disable (pmode_q[`SPM_AUTO_DISABLE_BIT]),
    .manual_mode         (manual_mode),
    .allow_deepest_sleep (pmode_q[`SPM_ALLOW_DEEP_BIT]),
    .pwm_active          (pwm_active),
    .auto_request        (auto_request),
    .active_mode         (active_mode)
  );
  assign conversions_enable = (active_mode != MODE_HALT);
  assign wake_channel_only  = (active_mode == MODE_DEEP);

  //////////////////////////////////////////////////////////////////////////////
  // millisecond and 16 ms unit ticks from the core clock
  logic [15:0] ms_cnt_q;  // core cycles within a millisecond
  logic [3:0]  u16_cnt_q; // milliseconds within a deep unit
  logic        ms_tick;
  logic        u16_tick;
  assign ms_tick  = (ms_cnt_q == 16'(MS_CYCLES - 1));
  assign u16_tick = ms_tick && (u16_cnt_q == 4'(`SPM_DEEP_UNIT_MS - 1));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q  <= '0;
      u16_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
      if (ms_tick) u16_cnt_q <= u16_cnt_q + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // report interval for the running mode
  logic [7:0]     interval;   // chosen interval value
  logic           unit_tick;  // chosen unit tick
  logic           timer_tick; // raw timer pulse
  power_mode_type last_mode_q;
  always_comb begin
    case (active_mode)
      MODE_NORMAL: interval = np_int_q;
      MODE_LOW:    interval = lp_int_q;
      MODE_DEEP:   interval = ulp_int_q;
      default:     interval = 8'hff;
    endcase
  end
  assign unit_tick = (active_mode == MODE_DEEP) ? u16_tick : ms_tick;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) last_mode_q <= MODE_NORMAL;
    else        last_mode_q <= active_mode;
  end
  report_timer #(.WIDTH(8)) u_report_timer (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .restart     (active_mode != last_mode_q || soft_pend_q),
    .unit_tick   (unit_tick),
    .interval    (interval),
    .report_tick (timer_tick)
  );
  assign report_tick = timer_tick && conversions_enable;

  //////////////////////////////////////////////////////////////////////////////
  // other channels in deep sleep run at a fraction of the deep rate
  logic [7:0] seg_cnt_q;  // deep reports seen
  logic [7:0] seg_mask;   // 2^(code+1) - 1
  assign seg_mask = 8'((16'h0002 << pmode_q[`SPM_SEG_RATE_HI:`SPM_SEG_RATE_LO]) - 16'h0001);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_cnt_q    <= '0;
      segment_tick <= 1'b0;
    end else begin
      segment_tick <= 1'b0;
      if (active_mode != MODE_DEEP) begin
        seg_cnt_q <= '0;
      end else if (report_tick) begin
        seg_cnt_q    <= seg_cnt_q + 8'h01;
        segment_tick <= ((seg_cnt_q & seg_mask) == seg_mask);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: registered data, soft reset, rerun and reseed bits read as pending, acknowledge bit and unmapped read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `SPM_SYSTEM_CONTROL_OFS:     rd_mux = {soft_pend_q, 1'b0, sys_cfg_q, rerun_pend_q, reseed_pend_q};
      `SPM_CHANNEL_ENABLES_OFS:    rd_mux = {2'b00, chan_en_q};
      `SPM_POWER_MODE_CONTROL_OFS: rd_mux = pmode_q;
      `SPM_NORMAL_INTERVAL_OFS:    rd_mux = np_int_q;
      `SPM_LOW_INTERVAL_OFS:       rd_mux = lp_int_q;
      `SPM_ULTRALOW_INTERVAL_OFS:  rd_mux = ulp_int_q;
      default:                     rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)      reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_soft_reset;
    @(posedge core_clk) disable iff (!rst_n)
      (soft_req && !soft_pend_q) |=> device_reset ##1 (!device_reset && chan_en_q == 6'h3f && pmode_q == 8'h03);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not reload defaults");
  property p_reset_event;
    @(posedge core_clk) disable iff (!rst_n)
      device_reset |=> reset_event;
  endproperty
  a_reset_event: assert property (p_reset_event) else $error("reset event not raised");
  property p_ack;
    @(posedge core_clk) disable iff (!rst_n)
      (ack_req && !soft_pend_q) |=> !reset_event;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not clear reset event");
  property p_comms;
    @(posedge core_clk) disable iff (!rst_n)
      (tuning_busy && !sys_cfg_q[1]) |-> !comms_allowed;
  endproperty
  a_comms: assert property (p_comms) else $error("comms allowed during tuning");
  property p_rerun;
    @(posedge core_clk) disable iff (!rst_n)
      (rerun_req && !rerun_pend_q && !soft_pend_q) |=> tuning_start && rerun_pend_q ##1 !tuning_start;
  endproperty
  a_rerun: assert property (p_rerun) else $error("rerun not started with one pulse");
  property p_reseed_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (reseed_pend_q && !reseed_done && !soft_pend_q) |=> reseed_pend_q;
  endproperty
  a_reseed_hold: assert property (p_reseed_hold) else $error("reseed bit cleared early");
  property p_pwm_normal;
    @(posedge core_clk) disable iff (!rst_n)
      pwm_active |-> (active_mode == MODE_NORMAL && !inductive_transmit_enable);
  endproperty
  a_pwm_normal: assert property (p_pwm_normal) else $error("pwm active outside normal mode");
  property p_halt;
    @(posedge core_clk) disable iff (!rst_n)
      (active_mode == MODE_HALT) |-> (!report_tick && !conversions_enable);
  endproperty
  a_halt: assert property (p_halt) else $error("activity in halt mode");
  property p_hall;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(chan_en_q[4]) |-> !hall_ui_ready;
  endproperty
  a_hall: assert property (p_hall) else $error("hall ready without channel four");
endmodule : system_power_mode_control
`default_nettype wire

// ==== rtl/spm_consts.svh ====
// offsets, field positions, reset values and timing figures of the power mode bank
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
// register offsets
`define SPM_SYSTEM_CONTROL_OFS      8'hd0
`define SPM_CHANNEL_ENABLES_OFS     8'hd1
`define SPM_POWER_MODE_CONTROL_OFS  8'hd2
`define SPM_NORMAL_INTERVAL_OFS     8'hd3
`define SPM_LOW_INTERVAL_OFS        8'hd4
`define SPM_ULTRALOW_INTERVAL_OFS   8'hd5
// reset values
`define SPM_SYSTEM_CONTROL_RST      8'h08
`define SPM_CHANNEL_ENABLES_RST     6'h3f
`define SPM_POWER_MODE_CONTROL_RST  8'h03
`define SPM_NORMAL_INTERVAL_RST     8'h10
`define SPM_LOW_INTERVAL_RST        8'h30
`define SPM_ULTRALOW_INTERVAL_RST   8'h08
// system control bit positions
`define SPM_SOFT_RESET_BIT          7
`define SPM_ACK_RESET_BIT           6
`define SPM_EVENT_MODE_BIT          5
`define SPM_SLOW_OSC_BIT            4
`define SPM_COMMS_TUNING_BIT        3
`define SPM_RETUNE_BAND_BIT         2
`define SPM_RERUN_TUNING_BIT        1
`define SPM_RESEED_BIT              0
// power mode control bit positions
`define SPM_PWM_OUT_BIT             7
`define SPM_ALLOW_DEEP_BIT          6
`define SPM_AUTO_DISABLE_BIT        5
`define SPM_MANUAL_MODE_HI          4
`define SPM_MANUAL_MODE_LO          3
`define SPM_SEG_RATE_HI             2
`define SPM_SEG_RATE_LO             0
// timing
`define SPM_CORE_CLK_PERIOD_NS      25
`define SPM_REPORT_UNIT_NS          1000000
`define SPM_DEEP_UNIT_MS            16
`endif

// ==== rtl/spm_pkg.sv ====
// types shared by the power mode bank
package spm_pkg;
  // power modes, coded as in the manual mode field
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_LOW    = 2'b01,
    MODE_DEEP   = 2'b10,
    MODE_HALT   = 2'b11
  } power_mode_type;
endpackage : spm_pkg

// ==== rtl/power_mode_select.sv ====
// picks the running power mode from pwm, manual and automatic choices
`timescale 1ns/1ps
`default_nettype none
module power_mode_select (
  input  wire logic                    auto_switch_disable,
  input  wire spm_pkg::power_mode_type manual_mode,
  input  wire logic                    allow_deepest_sleep,
  input  wire logic                    pwm_active,
  input  wire spm_pkg::power_mode_type auto_request,
  output var  spm_pkg::power_mode_type active_mode
);
  import spm_pkg::*;
  power_mode_type auto_pick; // automatic choice after the deep clamp
  // deep sleep is only reachable automatically when permitted, else stay low
  assign auto_pick = (auto_request == MODE_DEEP && !allow_deepest_sleep) ? MODE_LOW :
                     (auto_request == MODE_HALT) ? MODE_NORMAL : auto_request;
  // pwm pins normal mode, then manual beats automatic
  assign active_mode = pwm_active ? MODE_NORMAL :
                       auto_switch_disable ? manual_mode : auto_pick;
endmodule : power_mode_select
`default_nettype wire

// ==== rtl/report_timer.sv ====
// counts unit ticks and pulses once per programmed report interval
`timescale 1ns/1ps
`default_nettype none
module report_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             restart,
  input  wire logic             unit_tick,
  input  wire logic [WIDTH-1:0] interval,
  output var  logic             report_tick
);
  logic [WIDTH-1:0] count_q;    // units elapsed in this interval
  logic [WIDTH:0]   units_seen; // units including this tick, one bit wider so it cannot wrap
  logic             hit;        // interval reached on this tick
  // interval n gives one report per n units; zero is always met, so it fires every unit
  assign units_seen = {1'b0, count_q} + 1'b1;
  assign hit        = unit_tick && (units_seen >= {1'b0, interval});
  // count units, restart after each report or on request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q     <= '0;
      report_tick <= 1'b0;
    end else begin
      report_tick <= hit && !restart;
      if (restart || hit) begin
        count_q <= '0;
      end else if (unit_tick) begin
        count_q <= count_q + 1'b1;
      end
    end
  end
endmodule : report_timer
`default_nettype wire

// ==== dv/host_model.sv ====
// host model issuing single byte register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one byte write held over one rising edge; callers never pair a clock change with a rerun
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
  endtask : wr
  // one byte read, data taken once the answering edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ==== dv/system_power_mode_control_tb.sv ====
// self-checking bench for the system and power mode bank
`timescale 1ns/1ps
`default_nettype none
module system_power_mode_control_tb;
  import spm_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, tuning_busy, tuning_done, reseed_done, pwm_signal, inductive_tx_signal;
  power_mode_type auto_request, active_mode;
  logic device_reset, reset_event, event_mode, slow_oscillator_select, comms_allowed, retune_band_select;
  logic tuning_start, reseed_all, hall_ui_ready, temperature_ui_ready, sar_ui_ready, hysteresis_ui_ready;
  logic general_pin_three_out, inductive_transmit_enable, conversions_enable, wake_channel_only;
  logic report_tick, segment_tick;
  logic [5:0] channel_enable;
  int failures = 0;
  int check_count = 0;
  int n;
  always #12.5 core_clk = ~core_clk;
  system_power_mode_control #(.MS_CYCLES(20)) uut (.*);
  host_model host (.*);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
  endtask : rchk
  // cycles between two pulses of report_tick, or of segment_tick when seg is set
  task automatic period(input bit seg, output int c);
    c = 0;
    do @(negedge core_clk); while ((seg ? segment_tick : report_tick) !== 1'b1 && c++ < 1000);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while ((seg ? segment_tick : report_tick) !== 1'b1 && c < 1000);
  endtask : period
  ////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rchk(8'hd0, 8'h08);
    rchk(8'hd1, 8'h3f);
    rchk(8'hd2, 8'h03);
    rchk(8'hd3, 8'h10);
    rchk(8'hd4, 8'h30);
    rchk(8'hd5, 8'h08);
    rchk(8'hd6, 8'h00);
    chk("reset_event", 16'h1, {15'h0, reset_event});
    chk("pin idle", 16'h3, {14'h0, general_pin_three_out, inductive_transmit_enable});
  endtask : t_defaults
  task automatic t_sysbits();
    host.wr(8'hd0, 8'h3c);
    chk("sys outs", 16'h7, {event_mode, slow_oscillator_select, retune_band_select});
    rchk(8'hd0, 8'h3c);
    host.wr(8'hd0, 8'h00);
    chk("sys outs", 16'h0, {event_mode, slow_oscillator_select, retune_band_select});
  endtask : t_sysbits
  task automatic t_tuning();
    host.wr(8'hd0, 8'h02);
    chk("tuning_start", 16'h1, {15'h0, tuning_start});
    chk("comms pending", 16'h0, {15'h0, comms_allowed});
    rchk(8'hd0, 8'h02);
    tuning_busy = 1'b1;
    tuning_done = 1'b1;
    @(negedge core_clk);
    tuning_done = 1'b0;
    chk("comms busy", 16'h0, {15'h0, comms_allowed});
    rchk(8'hd0, 8'h00);
    host.wr(8'hd0, 8'h09);
    chk("reseed_all", 16'h1, {tuning_start, reseed_all});
    chk("comms on", 16'h1, {15'h0, comms_allowed});
    tuning_busy = 1'b0;
    reseed_done = 1'b1;
    @(negedge core_clk);
    reseed_done = 1'b0;
    rchk(8'hd0, 8'h08);
  endtask : t_tuning
  task automatic t_chan();
    host.wr(8'hd1, 8'h30);
    chk("ui", 16'h8, {hall_ui_ready, temperature_ui_ready, sar_ui_ready, hysteresis_ui_ready});
    host.wr(8'hd1, 8'h0f);
    chk("ui", 16'h7, {hall_ui_ready, temperature_ui_ready, sar_ui_ready, hysteresis_ui_ready});
    chk("enables", 16'h0f, {10'h0, channel_enable});
  endtask : t_chan
  task automatic t_modes();
    auto_request = MODE_LOW;
    for (int c = 0; c < 4; c++) begin
      host.wr(8'hd2, 8'h20 | 8'(c << 3));
      chk("manual", 16'(c), {14'h0, active_mode});
      chk("conv wake", {14'h0, c != 3, c == 2}, {conversions_enable, wake_channel_only});
    end
    host.wr(8'hd2, 8'h18);
    chk("auto", 16'h1, {14'h0, active_mode});
    auto_request = MODE_DEEP;
    host.wr(8'hd2, 8'h00);
    chk("no deep", 16'h1, {14'h0, active_mode});
    host.wr(8'hd2, 8'h40);
    chk("deep", 16'h2, {14'h0, active_mode});
    auto_request = MODE_HALT;
    @(negedge core_clk);
    chk("auto halt", 16'h0, {14'h0, active_mode});
    pwm_signal = 1'b1;
    inductive_tx_signal = 1'b0;
    host.wr(8'hd2, 8'hb8);
    chk("pwm", 16'h2, {active_mode, general_pin_three_out, inductive_transmit_enable});
  endtask : t_modes
  task automatic t_reset();
    host.wr(8'hd0, 8'h48);
    chk("ack", 16'h0, {15'h0, reset_event});
    host.wr(8'hd3, 8'h55);
    host.wr(8'hd0, 8'h88);
    chk("device_reset", 16'h1, {15'h0, device_reset});
    @(negedge core_clk);
    chk("event", 16'h1, {15'h0, reset_event});
    rchk(8'hd3, 8'h10);
    rchk(8'hd0, 8'h08);
  endtask : t_reset
  // one unit of the bench clock rate is 20 cycles per ms
  task automatic t_timer();
    host.wr(8'hd3, 8'h04); // four ms, the shortest the host relies on
    host.wr(8'hd2, 8'h20);
    period(1'b0, n);
    chk("normal period", 16'd80, 16'(n));
    host.wr(8'hd4, 8'h01);
    host.wr(8'hd2, 8'h28);
    period(1'b0, n);
    chk("low period", 16'd20, 16'(n));
    host.wr(8'hd5, 8'h01);
    host.wr(8'hd2, 8'h30);
    period(1'b0, n);
    chk("deep period", 16'd320, 16'(n));
    period(1'b1, n);
    chk("segment period", 16'd640, 16'(n));
    host.wr(8'hd2, 8'h38);
    chk("halt conv", 16'h0, {15'h0, conversions_enable});
    n = 0;
    repeat (400) begin
      @(negedge core_clk);
      if (report_tick === 1'b1) n++;
    end
    chk("halt reports", 16'h0, 16'(n));
  endtask : t_timer
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    tuning_busy = 1'b0;
    tuning_done = 1'b0;
    reseed_done = 1'b0;
    pwm_signal = 1'b0;
    inductive_tx_signal = 1'b1;
    auto_request = MODE_NORMAL;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    t_defaults();
    t_sysbits();
    t_tuning();
    t_chan();
    t_modes();
    t_reset();
    t_timer();
    summarize();
  end
  // hang guard well beyond the expected run
  initial begin
    #500000;
    failures++;
    summarize();
  end
endmodule : system_power_mode_control_tb
`default_nettype wire
